// ---- core/mmpc_params.svh ----
// Offsets, field positions, reset values and map constants of the memory map page control.
// Assumes inclusion by bare name from the design module.
`ifndef MMPC_PARAMS_SVH
`define MMPC_PARAMS_SVH
`define MMPC_OFF_PAGE 12'h0C0
`define MMPC_OFF_DIRECT 12'h0C4
`define MMPC_OFF_MODE 12'h0C8
`define MMPC_OFF_CTL 12'h0CC
`define MMPC_IDX_PAGE 8'h30
`define MMPC_IDX_DIRECT 8'h31
`define MMPC_IDX_MODE 8'h32
`define MMPC_IDX_CTL 8'h33
`define MMPC_PAGE_RST 8'hFE
`define MMPC_PAGE_FIX_MASK 8'hF0
`define MMPC_DIRECT_RST 8'h00
`define MMPC_MODE_BIT 7
`define MMPC_IFR_BIT 0
`define MMPC_PAGE_LOW 8'hFC
`define MMPC_PAGE_MID 8'hFD
`define MMPC_PAGE_TOP 8'hFF
`define MMPC_IFR_LO 18'h00400
`define MMPC_IFR_HI 18'h0047F
`endif

// ---- core/mmpc_pkg.sv ----
// Types shared by the memory map page control.
// Assumes nothing of its surroundings.
package mmpc_pkg;
	typedef enum logic {mmpc_special, mmpc_normal} mmpc_mode_t;
	typedef enum logic [1:0] {mmpc_run_reset, mmpc_run_capture, mmpc_run_active} mmpc_run_t;
endpackage

// ---- core/mmpc_core.sv ----
// Memory map page control: page index, direct page, mode bit, info row control, APB slave.
// Assumes APB master on pclk, CPU side signals synchronous to pclk, presetn async active low.
//
// Contract
// R1: Page index selects flash page in 0x8000-0xBFFF.
// R2: Local 0x0000-0x3FFF maps to page 0xFC.
// R3: Local 0x4000-0x7FFF maps to page 0xFD.
// R4: Local 0xC000-0xFFFF maps to page 0xFF.
// R5: Page index resets to 0xFE.
// R6: CPU call path writes page index immediately.
// R7: Direct page writable once in normal mode.
// R8: Direct addressing takes address bits from register.
// R9: Mode pin captured into mode bit at release.
// R10: Disallowed mode write locks further mode writes.
// R11: No mode change while secured.
// R12: Info row visible only when control bit set.
// R13: Normal mode blocks external accesses.
// R14: Special mode hands execution to background debug.
// R15: Global addresses are 18 bits wide.
// R16: Upper page bits read ones, ignore writes.
// R17: Special to normal allowed, reverse disallowed.
`timescale 1ns/1ns
`default_nettype none
`include "mmpc_params.svh"
module mmpc_core (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Mode strap and security.
	input wire logic mode_select_pin,
	input wire logic secured,
	// CPU call and return page path.
	input wire logic call_page_we,
	input wire logic [7:0] call_page_wdata,
	output logic [7:0] call_page_rdata,
	// Address translation.
	input wire logic [15:0] local_addr,
	input wire logic direct_access,
	output logic [17:0] global_addr,
	output logic info_row_visible,
	output logic info_row_hit,
	output logic external_bus_allowed,
	output logic background_debug_active,
	output logic normal_mode
);
	// Register bus decode.
	logic acc, rd_load, wr_take;
	logic [2:0] sel;
	// Answer and read data.
	logic pready_r, pready_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	// Start-up sequencing.
	mmpc_pkg::mmpc_run_t run_r, run_nxt;
	logic active;
	// Page index and translation.
	logic [3:0] page_r, page_nxt;
	logic [7:0] blk_page [4];
	logic [7:0] page_num;
	logic [15:0] eff_addr;
	// Direct page.
	logic [7:0] direct_r, direct_nxt;
	logic direct_done_r, direct_done_nxt;
	// Operating mode.
	logic mode_r, mode_nxt;
	logic mode_lock_r, mode_lock_nxt;
	logic mode_eff, special;
	mmpc_pkg::mmpc_mode_t mode_kind;
	// Info row control.
	logic ifr_r, ifr_nxt;

	// Forms the page register as seen by a reader.
	function automatic logic [7:0] page_view(input logic [3:0] idx);
		return `MMPC_PAGE_FIX_MASK | {4'h0, idx}; // [R16]
	endfunction

	// Picks the flash page number seen through one 16 kB block.
	function automatic logic [7:0] page_of(input logic [1:0] blk, input logic [3:0] idx);
		logic [7:0] p;
		p = `MMPC_PAGE_TOP;
		if (blk == 2'h0) begin
			p = `MMPC_PAGE_LOW; // [R2]
		end else if (blk == 2'h1) begin
			p = `MMPC_PAGE_MID; // [R3]
		end else if (blk == 2'h2) begin
			p = page_view(idx); // [R1]
		end else begin
			p = `MMPC_PAGE_TOP; // [R4]
		end
		return p;
	endfunction

	// Decodes a byte address into a hit flag and a register number.
	function automatic logic [2:0] reg_decode(input logic [11:0] a);
		logic [2:0] r;
		r = 3'h0;
		if (a == `MMPC_OFF_PAGE) begin
			r = 3'h4;
		end else if (a == `MMPC_OFF_DIRECT) begin
			r = 3'h5;
		end else if (a == `MMPC_OFF_MODE) begin
			r = 3'h6;
		end else if (a == `MMPC_OFF_CTL) begin
			r = 3'h7;
		end
		return r;
	endfunction

	// Builds the read word of one register.
	function automatic logic [31:0] reg_read(input logic [2:0] s, input logic [3:0] pg, input logic [7:0] dp,
		input logic md, input logic flash_info_row);
		logic [31:0] w;
		w = 32'h00000000;
		if (s == 3'h4) begin
			w = {24'h000000, page_view(pg)}; // [R16]
		end else if (s == 3'h5) begin
			w = {24'h000000, dp};
		end else if (s == 3'h6) begin
			w = {24'h000000, md, 7'h00}; // [R9]
		end else if (s == 3'h7) begin
			w = {31'h00000000, flash_info_row}; // [R12]
		end
		return w;
	endfunction

	// Tells whether a software write moves the mode bit.
	function automatic logic mode_moves(input logic now_special, input logic req, input logic sec);
		return !sec && now_special && req; // [R11] [R17]
	endfunction

	// Tells whether a software write asks for a refused transition.
	function automatic logic mode_refused(input logic now_special, input logic req);
		return !now_special && !req; // [R10] [R17]
	endfunction

	// Start-up: one edge to leave reset, one to capture the mode pin.
	always_comb begin
		run_nxt = run_r;
		case (run_r)
			mmpc_pkg::mmpc_run_reset: begin
				run_nxt = mmpc_pkg::mmpc_run_capture;
			end
			mmpc_pkg::mmpc_run_capture: begin
				run_nxt = mmpc_pkg::mmpc_run_active;
			end
			default: begin
				run_nxt = mmpc_pkg::mmpc_run_active;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r <= mmpc_pkg::mmpc_run_reset;
		end else begin
			run_r <= run_nxt;
		end
	end

	assign active = (run_r == mmpc_pkg::mmpc_run_active);

	// Bus decode: the answer comes one cycle into the access phase, with read data already registered.
	assign acc = psel & penable;
	assign sel = reg_decode(paddr);
	assign rd_load = acc & ~pready_r;
	assign wr_take = acc & pwrite & pready_r & pstrb[0];

	always_comb begin
		pready_nxt = acc & ~pready_r & active;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (rd_load) begin
			pslverr_nxt = ~sel[2];
			if (!pwrite) begin
				prdata_nxt = reg_read(sel, page_r, direct_r, mode_r, ifr_r);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= pready_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	// Page index: the call path wins over a bus write in the same cycle.
	always_comb begin
		page_nxt = page_r;
		if (call_page_we) begin
			page_nxt = call_page_wdata[3:0]; // [R6] [R16]
		end else if (wr_take && sel == 3'h4) begin
			page_nxt = pwdata[3:0]; // [R1] [R16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_r <= 4'(`MMPC_PAGE_RST); // [R5]
		end else begin
			page_r <= page_nxt;
		end
	end

	// Direct page: written any time in special mode, once in normal mode.
	always_comb begin
		direct_nxt = direct_r;
		direct_done_nxt = direct_done_r;
		if (wr_take && sel == 3'h5 && (special || !direct_done_r)) begin
			direct_nxt = pwdata[7:0]; // [R7]
			direct_done_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			direct_r <= `MMPC_DIRECT_RST;
			direct_done_r <= 1'b0;
		end else begin
			direct_r <= direct_nxt;
			direct_done_r <= direct_done_nxt;
		end
	end

	// Operating mode: captured from the pin, then changed only by allowed writes.
	always_comb begin
		mode_nxt = mode_r;
		mode_lock_nxt = mode_lock_r;
		if (run_r == mmpc_pkg::mmpc_run_capture) begin
			mode_nxt = mode_select_pin; // [R9]
		end else if (wr_take && sel == 3'h6 && (special || !mode_lock_r)) begin
			if (mode_moves(special, pwdata[`MMPC_MODE_BIT], secured)) begin
				mode_nxt = 1'b1; // [R17]
			end else if (mode_refused(special, pwdata[`MMPC_MODE_BIT])) begin
				mode_lock_nxt = 1'b1; // [R10]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= 1'b0;
			mode_lock_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			mode_lock_r <= mode_lock_nxt;
		end
	end

	assign mode_eff = active ? mode_r : mode_select_pin; // [R9]
	assign mode_kind = mmpc_pkg::mmpc_mode_t'(mode_eff);
	assign special = (mode_kind == mmpc_pkg::mmpc_special);

	// Info row control bit.
	always_comb begin
		ifr_nxt = ifr_r;
		if (wr_take && sel == 3'h7) begin
			ifr_nxt = pwdata[`MMPC_IFR_BIT]; // [R12]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ifr_r <= 1'b0;
		end else begin
			ifr_r <= ifr_nxt;
		end
	end

	// Address translation: every 16 kB block gets its page number.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_blk
			assign blk_page[g] = page_of(2'(g), page_r);
		end
	endgenerate

	assign call_page_rdata = page_view(page_r); // [R6]
	assign eff_addr = direct_access ? {direct_r, local_addr[7:0]} : local_addr; // [R8]
	assign page_num = blk_page[eff_addr[15:14]];
	assign global_addr = {page_num[3:0], eff_addr[13:0]}; // [R15]
	assign info_row_visible = ifr_r;
	assign info_row_hit = ifr_r && global_addr >= `MMPC_IFR_LO && global_addr <= `MMPC_IFR_HI; // [R12]
	assign normal_mode = mode_eff;
	assign external_bus_allowed = 1'b0; // [R13]
	assign background_debug_active = special; // [R14]
endmodule
`default_nettype wire

// ---- verif/mmpc_core_properties.sv ----
// Port checker of the page control.
// Assumes binding to mmpc_core on pclk.
`timescale 1ns/1ns
`default_nettype none
module mmpc_core_properties (
	// Watched ports.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic call_page_we,
	input wire logic [7:0] call_page_wdata,
	input wire logic [7:0] call_page_rdata,
	input wire logic [15:0] local_addr,
	input wire logic direct_access,
	input wire logic [17:0] global_addr,
	input wire logic external_bus_allowed,
	input wire logic background_debug_active,
	input wire logic normal_mode
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic [1:0] q = local_addr[15:14];
	wire logic [3:0] pg = global_addr[17:14];
	sequence s_call;
		call_page_we;
	endsequence
	property p_lo; !direct_access && q == 2'h0 |-> pg == 4'hC; endproperty
	a_lo: assert property (p_lo) else $error("low page wrong");
	property p_mid; !direct_access && q == 2'h1 |-> pg == 4'hD; endproperty
	a_mid: assert property (p_mid) else $error("mid page wrong");
	property p_top; !direct_access && q == 2'h3 |-> pg == 4'hF; endproperty
	a_top: assert property (p_top) else $error("top page wrong");
	property p_win; !direct_access && q == 2'h2 |-> pg == call_page_rdata[3:0]; endproperty
	a_win: assert property (p_win) else $error("window page wrong");
	property p_off; !direct_access |-> global_addr[13:0] == local_addr[13:0]; endproperty
	a_off: assert property (p_off) else $error("offset wrong");
	property p_ones; call_page_rdata[7:4] == 4'hF; endproperty
	a_ones: assert property (p_ones) else $error("upper bits wrong");
	property p_call; s_call |=> call_page_rdata[3:0] == $past(call_page_wdata[3:0]); endproperty
	a_call: assert property (p_call) else $error("call write lost");
	property p_ext; !external_bus_allowed && background_debug_active != normal_mode; endproperty
	a_ext: assert property (p_ext) else $error("mode outputs wrong");
endmodule
bind mmpc_core mmpc_core_properties chk (.pclk, .presetn, .call_page_we, .call_page_wdata, .call_page_rdata,
	.local_addr, .direct_access, .global_addr, .external_bus_allowed, .background_debug_active, .normal_mode);
`default_nettype wire

// ---- verif/mmpc_cpu_model.sv ----
// CPU side model: call path writes and local addresses.
// Assumes the bench calls its tasks.
`timescale 1ns/1ns
`default_nettype none
module mmpc_cpu_model (
	// CPU side.
	input wire logic pclk,
	output logic we = 1'b0,
	output logic [7:0] wd = 8'h00,
	output logic [15:0] la = 16'h0000,
	output logic dir = 1'b0
);
	task automatic call(input logic [7:0] d);
		@(posedge pclk);
		we <= 1'b1;
		wd <= d;
		@(posedge pclk);
		we <= 1'b0;
		wd <= ~d;
	endtask
	task automatic fetch(input logic [15:0] a, input logic d);
		@(posedge pclk);
		la <= a;
		dir <= d;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ---- verif/test_memory_map_page_control.sv ----
// Bench of the page control over APB.
// Assumes mmpc_core and the CPU model.
`timescale 1ns/1ns
`default_nettype none
module test_memory_map_page_control;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pin = 1'b0, sec = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic pready, pslverr, err, we, dir, vis, hit, ext, dbg, nm;
	logic [7:0] wd, rdp;
	logic [15:0] la;
	logic [17:0] ga;
	int errors = 0, checks_done = 0;
	initial forever #5 pclk = ~pclk;
	mmpc_cpu_model cpu (.pclk, .we, .wd, .la, .dir);
	mmpc_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
		.pslverr, .mode_select_pin(pin), .secured(sec), .call_page_we(we), .call_page_wdata(wd),
		.call_page_rdata(rdp), .local_addr(la), .direct_access(dir), .global_addr(ga), .info_row_visible(vis),
		.info_row_hit(hit), .external_bus_allowed(ext), .background_debug_active(dbg), .normal_mode(nm));
	task automatic chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic w = 1'b1);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		wr(a, 8'h00, 1'b0);
		chk(rdv, {24'h000000, e});
	endtask
	task automatic boot(input logic m);
		presetn <= 1'b0;
		pin <= m;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		pin <= ~m;
	endtask
	task automatic summarize;
		if (errors == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		boot(1'b1);
		rd(12'h0C0, 8'hFE);
		chk(32'(nm), 32'h00000001);
		cpu.fetch(16'h8000, 1'b0);
		chk(32'(ga), 32'h00038000);
		wr(12'h0C4, 8'h56);
		wr(12'h0C4, 8'h78);
		rd(12'h0C4, 8'h56);
		wr(12'h0C8, 8'h00);
		wr(12'h0C8, 8'h00);
		rd(12'h0C8, 8'h80);
		wr(12'h0D0, 8'h00);
		chk(32'(err), 32'h00000001);
		rd(12'h0D0, 8'h00);
		chk(32'(err), 32'h00000001);
		boot(1'b0);
		chk({30'h00000000, ext, dbg}, 32'h00000001);
		rd(12'h0C0, 8'hFE);
		wr(12'h0C4, 8'h12);
		wr(12'h0C4, 8'h34);
		rd(12'h0C4, 8'h34);
		sec <= 1'b1;
		wr(12'h0C8, 8'h80);
		rd(12'h0C8, 8'h00);
		sec <= 1'b0;
		wr(12'h0C8, 8'h80);
		rd(12'h0C8, 8'h80);
		wr(12'h0C0, 8'h07);
		rd(12'h0C0, 8'hF7);
		cpu.call(8'h05);
		rd(12'h0C0, 8'hF5);
		chk(32'(rdp), 32'h000000F5);
		cpu.fetch(16'h8123, 1'b0);
		chk(32'(ga), 32'h00014123);
		cpu.fetch(16'h4010, 1'b0);
		chk(32'(ga), 32'h00034010);
		cpu.fetch(16'hC100, 1'b0);
		chk(32'(ga), 32'h0003C100);
		cpu.fetch(16'h0056, 1'b1);
		chk(32'(ga), 32'h00033456);
		wr(12'h0C0, 8'h00);
		wr(12'h0CC, 8'h01);
		cpu.fetch(16'h8400, 1'b0);
		chk({30'h00000000, vis, hit}, 32'h00000003);
		wr(12'h0CC, 8'h00);
		@(negedge pclk);
		chk(32'(hit), 32'h00000000);
		summarize;
	end
	initial begin
		#50000;
		errors++;
		summarize;
	end
endmodule
`default_nettype wire
